// ===== core/cps_btn_if.sv
// Interface between the panel top and the pushbutton debouncer.
// Assumes one clock domain.
`timescale 1ns/10ps
`default_nettype none
interface cps_btn_if;
    logic press_pulse; // One-cycle pulse per clean press
    logic level;       // Debounced button level
    modport deb (output press_pulse, output level);
    modport top (input press_pulse, input level);
endinterface
`default_nettype wire

// ===== core/cps_debounce.sv
// Pushbutton debouncer: synchronised input to one pulse per press.
// Assumes the raw input is already synchronised to ref_clk.
`timescale 1ns/10ps
`default_nettype none
`include "cps_defines.svh"
module cps_debounce (
    // Clock, reset, enable
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    // Synchronised raw button
    input  wire logic btn_sync,
    // Clean outputs
    cps_btn_if.deb    btn
);
    logic [`CPS_DEB_W-1:0] cnt_reg;   // Stability counter
    logic                  level_reg; // Accepted level
    logic                  pulse_reg; // Press pulse
    wire                   differs;   // Raw differs from accepted
    wire                   stable;    // Raw held long enough
    assign differs = btn_sync != level_reg;
    assign stable  = cnt_reg == `CPS_DEB_W'(`CPS_DEBOUNCE_CYC - 1);

    // Accept a new level only after it stays put for the full count
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg   <= '0;
            level_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else if (clk_en) begin
            pulse_reg <= differs && stable && btn_sync;
            if (!differs) begin
                cnt_reg <= '0;
            end else if (stable) begin
                cnt_reg   <= '0;
                level_reg <= btn_sync;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end
    assign btn.press_pulse = pulse_reg;
    assign btn.level       = level_reg;
endmodule
`default_nettype wire

// ===== core/cps_defines.svh
// Constants for the correlator panel status block.
// Assumes a 100 MHz ref_clk; included by its bare name.
`ifndef CPS_DEFINES_SVH
`define CPS_DEFINES_SVH
// Clock period in ns
`define CPS_CLK_PERIOD_NS 10
// Least stable time of the pushbutton, in microseconds
`define CPS_DEBOUNCE_US 5
// Debounce count in cycles, rounded up
`define CPS_DEBOUNCE_CYC ((`CPS_DEBOUNCE_US * 1000 + `CPS_CLK_PERIOD_NS - 1) / `CPS_CLK_PERIOD_NS)
// Debounce counter width
`define CPS_DEB_W 10
// Resync pattern length in bits
`define CPS_RESYNC_BITS 8
// Bandwidth selector code for the standard 2 MHz band
`define CPS_BW_STANDARD 3'h2
// Counter function selector: delay
`define CPS_FUNC_DELAY 1'h0
// Counter function selector: fringe rate
`define CPS_FUNC_FRINGE 1'h1
`endif

// ===== core/cps_panel.sv
// Front-panel status and selection logic of the correlator controller.
// Assumes pins and switches are asynchronous; phase and events from
// the control computer and tape channels arrive on ref_clk.
//
// Overview of operation
// - One indicator per tape unit shows time-code source
// - Button toggles unit only when halted or idle
// - Separate ones and zeros activity indicators
// - Resync use sets dropout, held to frame end
// - Selector routes delay or fringe rate to counter
// - Two delay sign lights; none for fringe
// - Invalid-delay light when delay is shown and out of range
// - Time-constant selector picks display averaging
// - 2 MHz nominal; bandwidth and auto/cross selectors
// - Nonstandard_band_indicator light unless 2 MHz cross correlation
// - Computer light C0-C2, tracking C3-C4, exclusive
// - No valid phase leaves both lights dark
`timescale 1ns/10ps
`default_nettype none
`include "cps_defines.svh"
module cps_panel (
    // Clock, reset, enable
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    // Panel switches and pushbutton (asynchronous)
    input  wire logic       unit_button,
    input  wire logic       counter_func_sw,
    input  wire logic [2:0] bandwidth_sw,
    input  wire logic       autocorr_sw,
    input  wire logic [2:0] time_const_sw,
    // Tape unit bit activity, per unit (same clock)
    input  wire logic [1:0] ones_seen,
    input  wire logic [1:0] zeros_seen,
    // Resync and frame events, per unit (same clock)
    input  wire logic [1:0] resync_used,
    input  wire logic [1:0] frame_end,
    // Control computer (same clock)
    input  wire logic       computer_halted,
    input  wire logic       phase_valid,
    input  wire logic [2:0] computer_phase,
    input  wire logic [1:0] dropout_clear,
    // Delay and fringe-rate sources (same clock)
    input  wire logic       delay_gate,
    input  wire logic       delay_pulse,
    input  wire logic       delay_negative,
    input  wire logic       delay_overrange,
    input  wire logic       fringe_gate,
    input  wire logic       fringe_pulse,
    // Indicators
    output logic            unit_a_lamp,
    output logic            unit_b_lamp,
    output logic            ones_lamp,
    output logic            zeros_lamp,
    output logic [1:0]      resync_used_indicator,
    output logic            delay_minus_lamp,
    output logic            delay_plus_lamp,
    output logic            invalid_delay_lamp,
    output logic            nonstandard_band_indicator,
    output logic            computer_lamp,
    output logic            tracking_lamp,
    // External counter and correlator settings
    output logic            counter_gate_signal,
    output logic            counter_input_signal,
    output logic [2:0]      avg_select,
    output logic [2:0]      sample_rate_select,
    output logic            autocorr_mode
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops before any logic
    localparam int SW_W = 9; // Button, function, bandwidth, auto, tc
    logic [SW_W-1:0] sw_meta_reg; // First stage
    logic [SW_W-1:0] sw_sync_reg; // Second stage
    wire  [SW_W-1:0] sw_raw;      // Bundled pins
    assign sw_raw = {unit_button, counter_func_sw, bandwidth_sw,
                     autocorr_sw, time_const_sw};

    // Shift the asynchronous pins through two stages
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_meta_reg <= '0;
            sw_sync_reg <= '0;
        end else if (clk_en) begin
            sw_meta_reg <= sw_raw;
            sw_sync_reg <= sw_meta_reg;
        end
    end
    wire       btn_s  = sw_sync_reg[8];    // Button
    wire       func_s = sw_sync_reg[7];    // Counter function
    wire [2:0] bw_s   = sw_sync_reg[6:4];  // Bandwidth
    wire       auto_s = sw_sync_reg[3];    // Autocorrelation
    wire [2:0] tc_s   = sw_sync_reg[2:0];  // Time constant

    ////////////////////////////////////////////////////////////////////
    // Pushbutton debounce
    cps_btn_if btn_bus ();
    cps_debounce u_deb (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .btn_sync (btn_s),
        .btn      (btn_bus.deb)
    );

    ////////////////////////////////////////////////////////////////////
    // Phase decode, used for the unit gate and the lamps
    function automatic logic is_setup(input logic [2:0] ph);
        is_setup = ph == cps_pkg::idle_computer_phase ||
                   ph == cps_pkg::first_setup_phase ||
                   ph == cps_pkg::second_setup_phase;
    endfunction
    function automatic logic is_track(input logic [2:0] ph);
        is_track = ph == cps_pkg::tracking_entry_phase ||
                   ph == cps_pkg::steady_tracking_phase;
    endfunction
    wire phase_idle = phase_valid &&
         computer_phase == cps_pkg::idle_computer_phase;
    wire toggle_ok  = computer_halted || phase_idle;
    wire comp_next  = phase_valid && !computer_halted &&
                      is_setup(computer_phase);
    wire track_next = phase_valid && !computer_halted &&
                      is_track(computer_phase);

    ////////////////////////////////////////////////////////////////////
    // Unit selection
    cps_pkg::cps_unit_t unit_reg;  // Selected time-code unit
    cps_pkg::cps_unit_t unit_next; // Next selection
    assign unit_next = (btn_bus.press_pulse && toggle_ok) ?
        cps_pkg::cps_unit_t'(~unit_reg) : unit_reg;

    ////////////////////////////////////////////////////////////////////
    // Dropout flags: set wins over the computer's clear
    logic [1:0] drop_reg;  // Per-unit resync-used flags
    logic [1:0] drop_next; // Next flags
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_drop
            assign drop_next[gi] = resync_used[gi] ||
                (drop_reg[gi] && !dropout_clear[gi]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Selection and decode wires
    wire sel_b      = unit_reg == cps_pkg::cps_unit_b;
    wire ones_next  = sel_b ? ones_seen[1]  : ones_seen[0];
    wire zeros_next = sel_b ? zeros_seen[1] : zeros_seen[0];
    wire show_delay = func_s == `CPS_FUNC_DELAY;
    wire gate_next  = show_delay ? delay_gate  : fringe_gate;
    wire input_next = show_delay ? delay_pulse : fringe_pulse;
    wire minus_next = show_delay && delay_negative;
    wire plus_next  = show_delay && !delay_negative;
    wire narrow_next = (bw_s != `CPS_BW_STANDARD) || auto_s;

    ////////////////////////////////////////////////////////////////////
    // Output registers: every output straight from a flop
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            unit_reg                   <= cps_pkg::cps_unit_a;
            drop_reg                   <= 2'h0;
            unit_a_lamp                <= 1'b0;
            unit_b_lamp                <= 1'b0;
            ones_lamp                  <= 1'b0;
            zeros_lamp                 <= 1'b0;
            resync_used_indicator      <= 2'h0;
            delay_minus_lamp           <= 1'b0;
            delay_plus_lamp            <= 1'b0;
            invalid_delay_lamp         <= 1'b0;
            nonstandard_band_indicator <= 1'b0;
            computer_lamp              <= 1'b0;
            tracking_lamp              <= 1'b0;
            counter_gate_signal        <= 1'b0;
            counter_input_signal       <= 1'b0;
            avg_select                 <= 3'h0;
            sample_rate_select         <= 3'h0;
            autocorr_mode              <= 1'b0;
        end else if (clk_en) begin
            unit_reg                   <= unit_next;
            drop_reg                   <= drop_next;
            unit_a_lamp                <= !sel_b;
            unit_b_lamp                <= sel_b;
            ones_lamp                  <= ones_next;
            zeros_lamp                 <= zeros_next;
            resync_used_indicator      <= drop_next;
            delay_minus_lamp           <= minus_next;
            delay_plus_lamp            <= plus_next;
            invalid_delay_lamp         <= show_delay &&
                                          delay_overrange;
            nonstandard_band_indicator <= narrow_next;
            computer_lamp              <= comp_next;
            tracking_lamp              <= track_next;
            counter_gate_signal        <= gate_next;
            counter_input_signal       <= input_next;
            avg_select                 <= tc_s;
            sample_rate_select         <= bw_s;
            autocorr_mode              <= auto_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_unit_lamps_onehot: assert property (
        $past(rst_b) |-> (unit_a_lamp ^ unit_b_lamp))
        else $error("unit lamps not one-hot");
    a_toggle_gated: assert property (
        clk_en && btn_bus.press_pulse && !toggle_ok
        |=> $stable(unit_reg))
        else $error("unit toggled while computer busy");
    a_toggle_taken: assert property (
        clk_en && btn_bus.press_pulse && toggle_ok
        |=> unit_reg != $past(unit_reg))
        else $error("press ignored while allowed");
    a_ones_follow: assert property (
        clk_en && !sel_b |=> ones_lamp == $past(ones_seen[0]))
        else $error("ones lamp wrong for unit a");
    a_drop_hold: assert property (
        clk_en && resync_used[0] ##1 (clk_en && !dropout_clear[0])
        |=> resync_used_indicator[0])
        else $error("dropout not held");
    a_counter_route: assert property (
        clk_en && show_delay |=> counter_gate_signal == $past(delay_gate))
        else $error("counter gate not routed from delay");
    a_no_fringe_sign: assert property (
        clk_en && !show_delay |=> !delay_minus_lamp && !delay_plus_lamp)
        else $error("sign shown for fringe rate");
    a_narrow_band: assert property (
        clk_en && auto_s |=> nonstandard_band_indicator)
        else $error("nonstandard_band_indicator lamp off in autocorrelation");
    a_phase_exclusive: assert property (
        !(computer_lamp && tracking_lamp))
        else $error("both phase lamps lit");
    a_phase_dark: assert property (
        clk_en && !phase_valid |=> !computer_lamp && !tracking_lamp)
        else $error("phase lamp lit without valid phase");

    // Further checks on routing, dropout, selectors, phase decode and the press pulse. Each one
    // compares a flop with values sampled one enabled edge
    // earlier, so a frozen cycle with clk_en low never makes them fire.

    a_unit_b_follow: assert property (
        clk_en |=> unit_b_lamp == $past(sel_b))
        else $error("unit b lamp does not follow selection");

    a_zeros_follow: assert property (
        clk_en && sel_b |=> zeros_lamp == $past(zeros_seen[1]))
        else $error("zeros lamp wrong for unit b");

    a_drop_cleared: assert property (
        clk_en && !resync_used[1] && dropout_clear[1]
        |=> !resync_used_indicator[1])
        else $error("dropout not cleared at frame end");

    a_input_route: assert property (
        clk_en && !show_delay
        |=> counter_input_signal == $past(fringe_pulse))
        else $error("counter input not routed from fringe rate");

    a_minus_sign: assert property (
        clk_en && show_delay && delay_negative
        |=> delay_minus_lamp && !delay_plus_lamp)
        else $error("negative delay sign not shown");

    a_invalid_delay: assert property (
        clk_en && show_delay
        |=> invalid_delay_lamp == $past(delay_overrange))
        else $error("invalid delay lamp wrong");

    a_avg_follow: assert property (
        clk_en |=> avg_select == $past(tc_s))
        else $error("averaging select does not follow switch");

    a_rate_follow: assert property (
        clk_en |=> sample_rate_select == $past(bw_s) &&
                   autocorr_mode == $past(auto_s))
        else $error("rate or mode select does not follow switch");

    a_standard_band: assert property (
        clk_en && !auto_s && bw_s == `CPS_BW_STANDARD
        |=> !nonstandard_band_indicator)
        else $error("nonstandard_band_indicator lamp lit in standard band");

    a_track_lamp: assert property (
        clk_en && phase_valid && !computer_halted &&
        computer_phase == cps_pkg::steady_tracking_phase
        |=> tracking_lamp && !computer_lamp)
        else $error("tracking lamp off in steady tracking");

    a_halt_dark: assert property (
        clk_en && computer_halted |=> !computer_lamp && !tracking_lamp)
        else $error("phase lamp lit while computer halted");

    a_single_pulse: assert property (
        clk_en && btn_bus.press_pulse |=> !btn_bus.press_pulse)
        else $error("press pulse longer than one cycle");

    c_toggle: cover property (clk_en && btn_bus.press_pulse && toggle_ok);
    c_dropout: cover property (resync_used_indicator[0] ##1 dropout_clear[0]);
    c_tracking: cover property (tracking_lamp);
    c_fringe: cover property (clk_en && !show_delay && fringe_pulse);

    wire unused_ok = &{1'b0, btn_bus.level, frame_end};
endmodule
`default_nettype wire

// ===== core/cps_pkg.sv
// Types for the correlator panel status block.
// Assumes nothing of its surroundings.
package cps_pkg;
    // Computer phase as reported by the control computer
    typedef enum logic [2:0] {
        idle_computer_phase   = 3'h0,
        first_setup_phase     = 3'h1,
        second_setup_phase    = 3'h2,
        tracking_entry_phase  = 3'h3,
        steady_tracking_phase = 3'h4
    } cps_phase_t;
    // Selected tape unit
    typedef enum logic {
        cps_unit_a = 1'h0,
        cps_unit_b = 1'h1
    } cps_unit_t;
endpackage

// ===== dv/cps_far_model.sv
// Far-side model: two tape playback units and the control computer.
// Assumes requests from the bench change at the falling edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none
module cps_far_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // Requests from the bench
    input  wire logic [1:0] play_ones,
    input  wire logic [1:0] play_zeros,
    input  wire logic [1:0] resync_req,
    input  wire logic [1:0] frame_req,
    // Lines towards the panel
    output logic      [1:0] ones_seen,
    output logic      [1:0] zeros_seen,
    output logic      [1:0] resync_used,
    output logic      [1:0] frame_end,
    output logic      [1:0] dropout_clear
);
    ////////////////////////////////////////////////////////////////////
    // Launch on the falling edge so the panel samples settled lines
    always @(negedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ones_seen     <= 2'h0;
            zeros_seen    <= 2'h0;
            resync_used   <= 2'h0;
            frame_end     <= 2'h0;
            dropout_clear <= 2'h0;
        end else begin
            // Tape units report bit activity and resync events
            ones_seen     <= play_ones;
            zeros_seen    <= play_zeros;
            resync_used   <= resync_req;
            frame_end     <= frame_req;
            // Computer clears resync_used_indicator the cycle after each frame end
            dropout_clear <= frame_end;
        end
    end
endmodule
`default_nettype wire

// ===== dv/cps_panel_tb.sv
// Self-checking bench for the correlator panel status block.
// Assumes the far-side model drives the tape and dropout-clear lines.
`timescale 1ns/10ps
`default_nettype none
module cps_panel_tb;
    // Bench-driven inputs
    logic       ref_clk, rst_b, clk_en, unit_button, counter_func_sw;
    logic       autocorr_sw, computer_halted, phase_valid, delay_gate;
    logic       delay_pulse, delay_negative, delay_overrange, fringe_gate;
    logic       fringe_pulse;
    logic [2:0] bandwidth_sw, time_const_sw, computer_phase;
    logic [1:0] play_ones, play_zeros, resync_req, frame_req;
    // Far-side model lines
    logic [1:0] ones_seen, zeros_seen, resync_used, frame_end;
    logic [1:0] dropout_clear;
    // Panel outputs
    logic       unit_a_lamp, unit_b_lamp, ones_lamp, zeros_lamp;
    logic       delay_minus_lamp, delay_plus_lamp, invalid_delay_lamp;
    logic       nonstandard_band_indicator, computer_lamp, tracking_lamp;
    logic       counter_gate_signal, counter_input_signal, autocorr_mode;
    logic [1:0] resync_used_indicator;
    logic [2:0] avg_select, sample_rate_select;
    int         bad_count, tests_run;

    cps_panel i_cps_panel (.ref_clk, .rst_b, .clk_en, .unit_button,
        .counter_func_sw, .bandwidth_sw, .autocorr_sw, .time_const_sw,
        .ones_seen, .zeros_seen, .resync_used, .frame_end,
        .computer_halted, .phase_valid, .computer_phase, .dropout_clear,
        .delay_gate, .delay_pulse, .delay_negative, .delay_overrange,
        .fringe_gate, .fringe_pulse, .unit_a_lamp, .unit_b_lamp,
        .ones_lamp, .zeros_lamp, .resync_used_indicator, .delay_minus_lamp,
        .delay_plus_lamp, .invalid_delay_lamp, .nonstandard_band_indicator,
        .computer_lamp, .tracking_lamp, .counter_gate_signal,
        .counter_input_signal, .avg_select, .sample_rate_select,
        .autocorr_mode);
    cps_far_model i_cps_far_model (.ref_clk, .rst_b, .play_ones,
        .play_zeros, .resync_req, .frame_req, .ones_seen, .zeros_seen,
        .resync_used, .frame_end, .dropout_clear);

    ////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input string what, input logic [7:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Bouncy press and release; expect one toggle only if allowed
    task automatic press(input logic allowed);
        logic was_b;
        was_b = unit_b_lamp;
        for (int n = 0; n < 6; n++) begin
            unit_button <= ~n[0];
            cyc(30);
        end
        chk("bounce_unit_b", unit_b_lamp, was_b);
        unit_button <= 1'b1;
        cyc(700);
        chk("unit_b", unit_b_lamp, allowed ? !was_b : was_b);
        chk("unit_a", unit_a_lamp, !unit_b_lamp);
        unit_button <= 1'b0;
        cyc(700);
        chk("release_unit_b", unit_b_lamp, allowed ? !was_b : was_b);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_button;
        phase_valid <= 1'b1;
        computer_phase <= 3'h3;
        press(1'b0);
        computer_phase <= 3'h0;
        press(1'b1);
        play_ones <= 2'h2;
        play_zeros <= 2'h1;
        cyc(4);
        chk("ones_b", ones_lamp, 1'b1);
        chk("zeros_b", zeros_lamp, 1'b0);
        computer_halted <= 1'b1;
        phase_valid <= 1'b0;
        press(1'b1);
        cyc(4);
        chk("ones_a", ones_lamp, 1'b0);
        chk("zeros_a", zeros_lamp, 1'b1);
        $display("button test done");
    endtask
    task automatic test_dropout;
        for (int u = 0; u < 2; u++) begin
            chk("drop_idle", resync_used_indicator[u], 1'b0);
            resync_req <= 2'h1 << u;
            cyc(1);
            resync_req <= 2'h0;
            cyc(3);
            chk("drop_set", resync_used_indicator[u], 1'b1);
            cyc(8);
            chk("drop_held", resync_used_indicator[u], 1'b1);
            frame_req <= 2'h1 << u;
            cyc(1);
            frame_req <= 2'h0;
            cyc(4);
            chk("drop_clear", resync_used_indicator[u], 1'b0);
        end
        $display("dropout test done");
    endtask
    task automatic test_counter;
        logic m;
        logic s;
        delay_gate <= 1'b1;
        delay_pulse <= 1'b0;
        fringe_gate <= 1'b0;
        fringe_pulse <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            m = k[1];
            s = k[0];
            counter_func_sw <= m;
            delay_negative <= s;
            delay_overrange <= ~s;
            cyc(4);
            chk("cnt_gate", counter_gate_signal, !m);
            chk("cnt_input", counter_input_signal, m);
            chk("minus", delay_minus_lamp, !m && s);
            chk("plus", delay_plus_lamp, !m && !s);
            chk("invalid", invalid_delay_lamp, !m && !s);
        end
        $display("counter test done");
    endtask
    task automatic test_band;
        for (int k = 0; k < 16; k++) begin
            bandwidth_sw <= k[2:0];
            autocorr_sw <= k[3];
            time_const_sw <= ~k[2:0];
            cyc(4);
            chk("narrow", nonstandard_band_indicator,
                (k[2:0] != 3'h2) || k[3]);
            chk("rate", sample_rate_select, k[2:0]);
            chk("auto", autocorr_mode, k[3]);
            chk("avg", avg_select, 3'(~k[2:0]));
        end
        clk_en <= 1'b0;
        bandwidth_sw <= 3'h2;
        autocorr_sw <= 1'b0;
        cyc(6);
        chk("frozen", nonstandard_band_indicator, 1'b1);
        clk_en <= 1'b1;
        cyc(4);
        chk("standard", nonstandard_band_indicator, 1'b0);
        $display("band test done");
    endtask
    task automatic test_phase;
        computer_halted <= 1'b0;
        phase_valid <= 1'b1;
        for (int p = 0; p < 5; p++) begin
            computer_phase <= p[2:0];
            cyc(2);
            chk("comp_lamp", computer_lamp, p <= 2);
            chk("track_lamp", tracking_lamp, p >= 3);
        end
        phase_valid <= 1'b0;
        cyc(2);
        chk("dark_comp", computer_lamp, 1'b0);
        chk("dark_track", tracking_lamp, 1'b0);
        phase_valid <= 1'b1;
        computer_phase <= 3'h1;
        computer_halted <= 1'b1;
        cyc(2);
        chk("halt_comp", computer_lamp, 1'b0);
        // Reset the panel and the playback side before the computer restarts
        rst_b <= 1'b0;
        cyc(3);
        rst_b <= 1'b1;
        computer_halted <= 1'b0;
        cyc(3);
        chk("restart_comp", computer_lamp, 1'b1);
        chk("restart_unit", unit_a_lamp, 1'b1);
        $display("phase test done");
    endtask

    ////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Main sequence: quiet inputs, reset for 20 cycles, then scenarios
    initial begin
        {rst_b, unit_button, counter_func_sw, autocorr_sw} = 4'h0;
        {computer_halted, phase_valid, delay_gate, delay_pulse} = 4'h0;
        {delay_negative, delay_overrange, fringe_gate, fringe_pulse} = 4'h0;
        {bandwidth_sw, time_const_sw, computer_phase} = 9'h000;
        {play_ones, play_zeros, resync_req, frame_req} = 8'h00;
        clk_en = 1'b1;
        bad_count = 0;
        tests_run = 0;
        cyc(20);
        chk("reset_a", unit_a_lamp, 1'b0);
        chk("reset_b", unit_b_lamp, 1'b0);
        rst_b <= 1'b1;
        cyc(2);
        chk("start_a", unit_a_lamp, 1'b1);
        $display("reset test done");
        test_button();
        test_dropout();
        test_counter();
        test_band();
        test_phase();
        close_out();
    end
endmodule
`default_nettype wire
